// file: spi_select_and_master_control_tb_top.sv
/*
  Self-checking bench for ssc_spi_ctrl with a slave model on the pins.
  Assumes clock polarity 0, phase 0 for master transfers.
*/
`timescale 1ns/1ps
module spi_select_and_master_control_tb_top;
  import ssc_pkg::*;
  logic mclk_in = 0, srst_in = 1, spi_enable_bit_in, master_set_in, master_clear_in;
  logic select_disable_bit_in, select_ignore_bit_in, clock_phase_bit_in, clock_polarity_bit_in;
  logic data_order_bit_in, enhanced_interrupt_bit_in, spi_irq_enable_in, data_wr_in;
  logic txe_clear_in, done_clear_in, fault_clear_in, rx_ready_in, sck_in, mosi_in, miso_in;
  logic ss_n_in, rx_valid_out, master_select_bit_out, transmit_empty_flag_out, busy_out;
  logic transfer_complete_flag_out, mode_fault_flag_out, spi_irq_out, sck_out, sck_oe_n_out;
  logic mosi_out, mosi_oe_n_out, miso_out, miso_oe_n_out, sel_n, model_miso, stall;
  logic [RATE_W-1:0] rate_sel_in;
  ssc_pin_mode_e     pin_mode_in;
  logic [7:0]        data_wdata_in, rx_data_out, tx_byte, model_rx, b0, b1, exp_q[$];
  int                edges, n_mismatch = 0, checks = 0, cyc = 0, seed;
  // Wire levels: released miso shows the slave, sck pulls low, mosi pulls high
  assign miso_in = miso_oe_n_out ? model_miso : miso_out;
  ssc_spi_ctrl dut (.*);
  ssc_slave_model slv (.sck_in(!sck_oe_n_out && sck_out), .mosi_in(mosi_oe_n_out || mosi_out),
    .sel_n_in(sel_n), .tx_byte_in(tx_byte), .miso_out(model_miso), .rx_byte_out(model_rx),
    .edge_cnt_out(edges));
  always #5 mclk_in = ~mclk_in;
  // Hang guard and receiver stalls
  always @(posedge mclk_in) begin
    rx_ready_in <= stall ? 1'b0 : 1'($urandom_range(1));
    if (++cyc == 30000) begin n_mismatch++; finish_test(); end
  end
  // Received bytes checked against the oldest note
  always @(posedge mclk_in) if (!srst_in && rx_valid_out && rx_ready_in) begin
    if (exp_q.size() == 0) chk("extra rx", 8'h00, 8'h01);
    else chk("rx byte", rx_data_out, exp_q.pop_front());
  end
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7-i];
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk_in);
  endtask
  // Pulse one control: 0 set master, 1 clear master, 2 clear done, 3 clear fault
  task automatic pulse(input int k);
    case (k) 0: master_set_in <= 1; 1: master_clear_in <= 1; 2: done_clear_in <= 1;
      default: fault_clear_in <= 1; endcase
    tick();
    {master_set_in, master_clear_in, done_clear_in, fault_clear_in} <= 4'h0;
    tick();
  endtask
  task automatic wr(input logic [7:0] b);
    data_wr_in <= 1;
    data_wdata_in <= b;
    tick();
    data_wr_in <= 0;
    tick();
  endtask
  // Wait for a flag: 0 transmit empty, 1 complete, 2 mode fault
  task automatic wait_for(input int k);
    int n;
    n = 0;
    while (!(k == 0 ? transmit_empty_flag_out : k == 1 ? transfer_complete_flag_out :
      mode_fault_flag_out) && n < 500) begin tick(); n++; end
    chk("flag wait", 8'(n < 500), 8'h01);
  endtask
  task automatic drain(input int t);
    stall = 0;
    for (int n = 0; n < 200 && exp_q.size() > 0; n++) tick();
    chk("rx drained", 8'(exp_q.size()), 8'h00);
    sel_n <= 1;
    $display("test %0d done", t);
  endtask
  initial begin
    {spi_enable_bit_in, master_set_in, master_clear_in, select_disable_bit_in} = 4'h0;
    {select_ignore_bit_in, clock_phase_bit_in, clock_polarity_bit_in, data_order_bit_in} = 4'h0;
    {enhanced_interrupt_bit_in, spi_irq_enable_in, data_wr_in, txe_clear_in} = 4'h0;
    {done_clear_in, fault_clear_in, sck_in, mosi_in} = 4'h0;
    rate_sel_in = 3'h2;
    pin_mode_in = SSC_PIN_PUSH;
    data_wdata_in = 8'h00;
    {ss_n_in, sel_n, stall} = 3'b111;
    tx_byte = 8'h00;
    seed = $urandom(27364);
    tick(6);
    srst_in <= 0;
    tick();
    chk("reset flags", {master_select_bit_out, transmit_empty_flag_out,
      transfer_complete_flag_out, mode_fault_flag_out}, 8'h04);
    spi_enable_bit_in <= 1;
    select_ignore_bit_in <= 1;
    spi_irq_enable_in <= 1;
    pulse(0);
    // Two buffered bytes per data order, receiver stalled until both land
    for (int d = 0; d < 2; d++) begin
      data_order_bit_in <= d[0];
      enhanced_interrupt_bit_in <= d[0];
      stall = 1;
      tx_byte <= 8'($urandom);
      b0 = 8'($urandom);
      b1 = 8'($urandom);
      tick();
      sel_n <= 0;
      repeat (2) exp_q.push_back(d ? rev(tx_byte) : tx_byte);
      wr(b0);
      wait_for(0);
      chk("txe irq", spi_irq_out, 8'(d));
      wr(b1);
      chk("txe", transmit_empty_flag_out, 8'h00);
      wait_for(1);
      pulse(2);
      wait_for(1);
      chk("sck edges", 8'(edges), 8'h10);
      chk("mosi byte", model_rx, d ? rev(b1) : b1);
      chk("buffer full", busy_out, 8'h01);
      pulse(2);
      drain(1);
    end
    // Mode fault in mid transfer
    select_ignore_bit_in <= 0;
    sel_n <= 0;
    wr(8'hA5);
    tick(20);
    ss_n_in <= 0;
    wait_for(2);
    chk("fault irq", spi_irq_out, 8'h01);
    tick(2);
    chk("master", master_select_bit_out, 8'h00);
    chk("done", transfer_complete_flag_out, 8'h00);
    chk("sck oe", sck_oe_n_out, 8'h01);
    ss_n_in <= 1;
    select_disable_bit_in <= 1;
    tick();
    select_disable_bit_in <= 0;
    tick(4);
    chk("fault kept", mode_fault_flag_out, 8'h01);
    pulse(3);
    chk("fault clear", mode_fault_flag_out, 8'h00);
    tick(10);
    chk("master off", master_select_bit_out, 8'h00);
    pulse(0);
    chk("master back", master_select_bit_out, 8'h01);
    drain(2);
    // Select low ignored through select-ignore, then select-disable
    data_order_bit_in <= 0;
    for (int k = 0; k < 2; k++) begin
      select_ignore_bit_in <= k == 0;
      select_disable_bit_in <= k == 1;
      tick(2);
      sel_n <= 0;
      ss_n_in <= 0;
      exp_q.push_back(tx_byte);
      wr(8'($urandom));
      wait_for(1);
      chk("master held", {master_select_bit_out, mode_fault_flag_out}, 8'h02);
      ss_n_in <= 1;
      pulse(2);
      drain(3);
    end
    // Slave output enable against select, phase and select-disable
    select_ignore_bit_in <= 0;
    pulse(1);
    for (int k = 0; k < 3; k++) begin
      ss_n_in <= k != 1;
      clock_phase_bit_in <= k == 2;
      select_disable_bit_in <= k == 2;
      tick(6);
      chk("miso oe", miso_oe_n_out, 8'(k == 0));
    end
    $display("test 4 done");
    finish_test();
  end
endmodule

// file: ssc_buf2.sv
/*
  Two-entry valid/ready buffer carrying received bytes.
  Assumes the same clock and synchronous reset as its parent.
*/
`timescale 1ns/1ps
module ssc_buf2 (
  // Clock and reset
  input  wire logic                      mclk_in,
  input  wire logic                      srst_in,
  // Fill side
  input  wire logic                      in_valid_in,
  output logic                           in_ready_out,
  input  wire logic [ssc_pkg::BYTE_W-1:0] in_data_in,
  // Drain side
  output logic                           out_valid_out,
  input  wire logic                      out_ready_in,
  output logic [ssc_pkg::BYTE_W-1:0]     out_data_out
);
  import ssc_pkg::*;

  logic [BYTE_W-1:0] mem_q [2];
  logic              wptr_q;
  logic              rptr_q;
  logic [1:0]        cnt_q;
  logic              push;
  logic              pop;

  // Handshakes and honest full/empty
  assign in_ready_out  = (cnt_q != 2'h2);
  assign out_valid_out = (cnt_q != 2'h0);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_data_out  = mem_q[rptr_q];

  // Storage writes
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_q[wptr_q] <= in_data_in;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wptr_q <= 1'b0;
      rptr_q <= 1'b0;
      cnt_q  <= 2'h0;
    end else begin
      if (push) begin
        wptr_q <= ~wptr_q;
      end
      if (pop) begin
        rptr_q <= ~rptr_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// file: ssc_pkg.sv
/*
  Shared constants and types for the SPI select and master control block.
  Assumes a single 100 MHz system clock and plain-port control bits.
*/
package ssc_pkg;
  // System clock period in ns
  localparam int CLK_PERIOD_NS = 10;
  // Byte width and bit count per transfer
  localparam int BYTE_W = 8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Baud prescaler selection width and base step of the divider
  localparam int RATE_W = 3;
  localparam logic [7:0] DIV_BASE = 8'h01;
  // Pin drive styles for the master-output line
  typedef enum logic [1:0] {
    SSC_PIN_QUASI = 2'b00,
    SSC_PIN_PUSH  = 2'b01,
    SSC_PIN_INPUT = 2'b10,
    SSC_PIN_OPEN  = 2'b11
  } ssc_pin_mode_e;
  // Master shifter states
  typedef enum logic [1:0] {
    SSC_IDLE  = 2'b00,
    SSC_ALIGN = 2'b01,
    SSC_LEAD  = 2'b10,
    SSC_TRAIL = 2'b11
  } ssc_state_e;
  // Reset values of control and status state
  localparam logic       RST_FLAG  = 1'b0;
  localparam logic       RST_TXE   = 1'b1;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [7:0] RST_DIV   = 8'h00;
  localparam logic [2:0] RST_BIT   = 3'h0;
endpackage

// file: ssc_slave_model.sv
/*
  Behavioural SPI slave standing on the far side of the master pins.
  Assumes clock polarity 0 and phase 0: data changes on falling sck.
*/
`timescale 1ns/1ps
module ssc_slave_model (
  input  wire logic       sck_in,
  input  wire logic       mosi_in,
  input  wire logic       sel_n_in,
  input  wire logic [7:0] tx_byte_in,
  output logic            miso_out = 1'b0,
  output logic [7:0]      rx_byte_out,
  output int              edge_cnt_out
);
  logic [7:0] sh_q;
  // Select falls: load reply byte and present its first bit; select held low per frame
  always @(negedge sel_n_in) begin
    sh_q = tx_byte_in;
    edge_cnt_out = 0;
    miso_out = tx_byte_in[7];
  end
  // Released line shows the inverse of the last bit
  always @(posedge sel_n_in) miso_out = ~miso_out;
  // Capture master data and count leading edges
  always @(posedge sck_in) if (!sel_n_in) begin
    rx_byte_out = {rx_byte_out[6:0], mosi_in};
    edge_cnt_out++;
  end
  // Rotate so each byte of a frame repeats the reply
  always @(negedge sck_in) if (!sel_n_in) begin
    sh_q = {sh_q[6:0], sh_q[7]};
    miso_out = sh_q[7];
  end
endmodule

// file: ssc_spi_ctrl.sv
/*
  SPI select handling, pin direction, master transmit buffering, transmit-empty
  and transfer-complete flags, and mode-fault detection.
  Assumes control bits arrive as plain ports from same-clock software logic and
  the SPI pins arrive unsynchronised from the pads.
*/
// Summary of operation
// - As slave, slave-output floats whenever select is high, unless clock-phase and select-disable are both set.
// - Master with select-disable set: select pin is ignored, no mode fault.
// - Clearing select-disable leaves a set mode fault flag alone.
// - Slave with clock-phase and select-disable set counts as always selected.
// - Select low as master without select-ignore or select-disable drops master, clock and master-output pins become inputs.
// - That event sets mode fault and raises the interrupt when enabled.
// - Master bit stays cleared after a fault until software sets it again.
// - With SPI enabled and pin mode not input, pin directions follow the master bit; input mode leaves all pins as inputs.
// - Master-output driven only in transfers; idle pulled high or tristated.
// - Master data write loads buffer; empty shifter takes it, flag sets, transfer starts.
// - First clock edge waits for the next full baud bit period.
// - Byte end sets complete flag, stores received byte unless both receive entries are full, interrupts when enabled.
// - Transmit-empty clears by software or any data write, even mid-transfer.
// - A waiting byte starts the next transfer when one ends.
// - Transmit-empty interrupts only with interrupt enable and enhanced bit set.
// - Select-ignore set: select pin ignored, master stays, no mode fault.
// - A master transfer gives exactly eight clock cycles.
// - Most significant bit first unless the data-order bit picks least first.
`timescale 1ns/1ps
module ssc_spi_ctrl (
  // Clock and reset
  input  wire logic                        mclk_in,
  input  wire logic                        srst_in,
  // Control bits
  input  wire logic                        spi_enable_bit_in,
  input  wire logic                        master_set_in,
  input  wire logic                        master_clear_in,
  input  wire logic                        select_disable_bit_in,
  input  wire logic                        select_ignore_bit_in,
  input  wire logic                        clock_phase_bit_in,
  input  wire logic                        clock_polarity_bit_in,
  input  wire logic                        data_order_bit_in,
  input  wire logic                        enhanced_interrupt_bit_in,
  input  wire logic                        spi_irq_enable_in,
  input  wire logic [ssc_pkg::RATE_W-1:0]  rate_sel_in,
  input  wire ssc_pkg::ssc_pin_mode_e      pin_mode_in,
  // Data register write and flag clears
  input  wire logic                        data_wr_in,
  input  wire logic [ssc_pkg::BYTE_W-1:0]  data_wdata_in,
  input  wire logic                        txe_clear_in,
  input  wire logic                        done_clear_in,
  input  wire logic                        fault_clear_in,
  // Receive stream, read of the data register
  output logic                             rx_valid_out,
  input  wire logic                        rx_ready_in,
  output logic [ssc_pkg::BYTE_W-1:0]       rx_data_out,
  // Status
  output logic                             master_select_bit_out,
  output logic                             transmit_empty_flag_out,
  output logic                             transfer_complete_flag_out,
  output logic                             mode_fault_flag_out,
  output logic                             busy_out,
  output logic                             spi_irq_out,
  // Serial clock pin
  input  wire logic                        sck_in,
  output logic                             sck_out,
  output logic                             sck_oe_n_out,
  // Master-output pin
  input  wire logic                        mosi_in,
  output logic                             mosi_out,
  output logic                             mosi_oe_n_out,
  // Slave-output pin
  output logic                             miso_out,
  output logic                             miso_oe_n_out,
  input  wire logic                        miso_in,
  // Select pin
  input  wire logic                        ss_n_in
);
  import ssc_pkg::*;

  ssc_state_e        state_q;
  logic [1:0]        ss_sync_q;
  logic [1:0]        miso_sync_q;
  logic              master_q;
  logic              fault_q;
  logic              done_q;
  logic              txe_q;
  logic              buf_full_q;
  logic [BYTE_W-1:0] buf_q;
  logic [BYTE_W-1:0] shift_q;
  logic [2:0]        bit_q;
  logic [7:0]        div_q;
  logic              sck_q;
  logic              mosi_q;
  logic              tick;
  logic              fault_evt;
  logic              load_shift;
  logic              byte_end;
  logic              rx_push;
  logic              rx_ready;
  logic              sample_bit;
  logic              selected;
  logic              drive_mosi;
  logic [7:0]        div_last;

  // Pads pass two flip-flops before use
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ss_sync_q   <= 2'b11;
      miso_sync_q <= 2'b11;
    end else begin
      ss_sync_q   <= {ss_sync_q[0], ss_n_in};
      miso_sync_q <= {miso_sync_q[0], miso_in};
    end
  end

  // Fault: only master, select honoured, and select low
  assign fault_evt = spi_enable_bit_in && master_q && !select_ignore_bit_in
                     && !select_disable_bit_in && !ss_sync_q[1];

  // Master bit: software sets, a fault clears and holds it clear
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      master_q <= RST_FLAG;
    end else if (fault_evt) begin
      master_q <= 1'b0;
    end else if (master_set_in) begin
      master_q <= 1'b1;
    end else if (master_clear_in) begin
      master_q <= 1'b0;
    end
  end

  // Mode fault flag; set wins over clear, select-disable never clears it
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      fault_q <= RST_FLAG;
    end else if (fault_evt) begin
      fault_q <= 1'b1;
    end else if (fault_clear_in) begin
      fault_q <= 1'b0;
    end
  end

  // Baud divider: half-period is DIV_BASE shifted by the rate selection
  assign div_last = (DIV_BASE << rate_sel_in) - DIV_BASE;
  assign tick     = (div_q >= div_last);
  always_ff @(posedge mclk_in) begin
    if (srst_in || tick) begin
      div_q <= RST_DIV;
    end else begin
      div_q <= div_q + DIV_BASE;
    end
  end

  // Byte movement conditions
  assign load_shift = buf_full_q && (state_q == SSC_IDLE) && master_q && spi_enable_bit_in;
  assign byte_end   = tick && (state_q == SSC_TRAIL) && (bit_q == RST_BIT - 3'h1) && !fault_evt;
  assign sample_bit = miso_sync_q[1];

  // Transmit buffer and transmit-empty flag
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      buf_q      <= RST_BYTE;
      buf_full_q <= RST_FLAG;
      txe_q      <= RST_TXE;
    end else if (data_wr_in) begin
      buf_q      <= data_wdata_in;
      buf_full_q <= 1'b1;
      txe_q      <= 1'b0;
    end else if (load_shift) begin
      buf_full_q <= 1'b0;
      txe_q      <= 1'b1;
    end else if (txe_clear_in) begin
      txe_q      <= 1'b0;
    end
  end

  // Master shifter: align to a bit period, then eight lead/trail pairs
  always_ff @(posedge mclk_in) begin
    if (srst_in || fault_evt || !spi_enable_bit_in) begin
      state_q <= SSC_IDLE;
      bit_q   <= RST_BIT;
      sck_q   <= 1'b0;
      shift_q <= RST_BYTE;
    end else begin
      unique case (state_q)
        SSC_IDLE: begin
          if (load_shift) begin
            shift_q <= buf_q;
            state_q <= SSC_ALIGN;
          end
        end
        SSC_ALIGN: begin
          if (tick) begin
            state_q <= SSC_LEAD;
          end
        end
        SSC_LEAD: begin
          if (tick) begin
            sck_q   <= 1'b1;
            state_q <= SSC_TRAIL;
          end
        end
        SSC_TRAIL: begin
          if (tick) begin
            sck_q   <= 1'b0;
            bit_q   <= bit_q + 3'h1;
            shift_q <= data_order_bit_in ?
                       {sample_bit, shift_q[BYTE_W-1:1]} :
                       {shift_q[BYTE_W-2:0], sample_bit};
            state_q <= (bit_q == RST_BIT - 3'h1) ? SSC_IDLE : SSC_LEAD;
          end
        end
      endcase
    end
  end

  // Outgoing data bit held in a flip-flop
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      mosi_q <= 1'b1;
    end else begin
      mosi_q <= data_order_bit_in ? shift_q[0] : shift_q[BYTE_W-1];
    end
  end

  // Transfer complete flag; set wins over clear
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      done_q <= RST_FLAG;
    end else if (byte_end) begin
      done_q <= 1'b1;
    end else if (done_clear_in) begin
      done_q <= 1'b0;
    end
  end

  // Received byte lands in the buffer at the end of each byte unless both entries are full
  assign rx_push = byte_end;
  ssc_buf2 u_rx_buf (
    .mclk_in      (mclk_in),
    .srst_in      (srst_in),
    .in_valid_in  (rx_push),
    .in_ready_out (rx_ready),
    .in_data_in   (data_order_bit_in ? {sample_bit, shift_q[BYTE_W-1:1]}
                                     : {shift_q[BYTE_W-2:0], sample_bit}),
    .out_valid_out(rx_valid_out),
    .out_ready_in (rx_ready_in),
    .out_data_out (rx_data_out)
  );

  // Pin directions; output enables are active low
  assign selected   = !ss_sync_q[1] || (clock_phase_bit_in && select_disable_bit_in);
  assign drive_mosi = master_q && (state_q != SSC_IDLE);
  always_comb begin
    sck_oe_n_out  = 1'b1;
    mosi_oe_n_out = 1'b1;
    miso_oe_n_out = 1'b1;
    sck_out       = clock_polarity_bit_in ^ sck_q;
    mosi_out      = drive_mosi ? mosi_q : 1'b1;
    miso_out      = mosi_q;
    if (spi_enable_bit_in && pin_mode_in != SSC_PIN_INPUT) begin
      if (master_q) begin
        sck_oe_n_out  = 1'b0;
        // Idle line pulled high except in push-pull, where it floats
        mosi_oe_n_out = !(drive_mosi || pin_mode_in != SSC_PIN_PUSH);
      end else begin
        miso_oe_n_out = !selected;
      end
    end
  end

  // Status and interrupt request
  assign master_select_bit_out      = master_q;
  assign transmit_empty_flag_out    = txe_q;
  assign transfer_complete_flag_out = done_q;
  assign mode_fault_flag_out        = fault_q;
  assign busy_out                   = (state_q != SSC_IDLE) || !rx_ready;
  assign spi_irq_out = spi_irq_enable_in &&
                       (done_q || fault_q || (txe_q && enhanced_interrupt_bit_in));
endmodule

// file: ssc_spi_ctrl_checker.sv
/*
  Port assertions for the SPI select and master control block.
  Assumes one clock and the synchronous reset; bound below.
*/
`timescale 1ns/1ps
module ssc_spi_ctrl_checker (
  input wire logic mclk_in, srst_in, spi_enable_bit_in, master_set_in, master_clear_in,
  input wire logic select_disable_bit_in, select_ignore_bit_in, clock_phase_bit_in,
  input wire logic enhanced_interrupt_bit_in, spi_irq_enable_in, data_wr_in,
  input wire logic done_clear_in, fault_clear_in, rx_valid_out, master_select_bit_out,
  input wire logic transmit_empty_flag_out, transfer_complete_flag_out, mode_fault_flag_out,
  input wire logic spi_irq_out, sck_oe_n_out, mosi_oe_n_out, miso_oe_n_out, ss_n_in
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  a_fault_drop:
    assert property ((!ss_n_in && !select_ignore_bit_in && !select_disable_bit_in &&
      spi_enable_bit_in && !master_set_in)[*4] |-> !master_select_bit_out) else $error("master kept");
  a_fault_flag:
    assert property ($fell(master_select_bit_out) && !$past(master_clear_in) |->
      mode_fault_flag_out) else $error("fault flag missing");
  a_no_fault_ign:
    assert property ((select_ignore_bit_in || select_disable_bit_in)[*4] |->
      !$rose(mode_fault_flag_out)) else $error("fault while ignored");
  a_master_stays_off:
    assert property (!master_select_bit_out && !master_set_in |=> !master_select_bit_out)
      else $error("master restored");
  a_fault_holds:
    assert property (mode_fault_flag_out && !fault_clear_in |=> mode_fault_flag_out)
      else $error("fault flag lost");
  a_done_holds:
    assert property (transfer_complete_flag_out && !done_clear_in |=> transfer_complete_flag_out)
      else $error("complete flag lost");
  a_done_rx:
    assert property ($rose(transfer_complete_flag_out) |-> rx_valid_out) else $error("no rx");
  a_txe_write:
    assert property (data_wr_in |=> !transmit_empty_flag_out) else $error("txe kept");
  a_irq_cause:
    assert property (spi_irq_out |-> spi_irq_enable_in && (transfer_complete_flag_out ||
      mode_fault_flag_out || transmit_empty_flag_out && enhanced_interrupt_bit_in))
      else $error("irq without cause");
  a_slave_pins:
    assert property ((!master_select_bit_out)[*2] |-> sck_oe_n_out && mosi_oe_n_out)
      else $error("slave drives pins");
  a_miso_off:
    assert property ((ss_n_in && !(clock_phase_bit_in && select_disable_bit_in))[*4] |->
      miso_oe_n_out) else $error("miso driven");
endmodule
bind ssc_spi_ctrl ssc_spi_ctrl_checker u_chk (.*);
